/* File: hdl/dcr_cfg.svh */
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH

`define DCR_OFS_INIT 12'h200
`define DCR_OFS_ISTAT 12'h204
`define DCR_OFS_DMODE 12'h210
`define DCR_OFS_PORT 12'h214
`define DCR_OFS_FDATA 12'h218
`define DCR_OFS_FSTAT 12'h21C
`define DCR_OFS_PATTERN 12'h220
`define DCR_OFS_IEN 12'h224
`define DCR_OFS_SCAN 12'h22C
`define DCR_OFS_PACER 12'h244
`define DCR_OFS_TRIG 12'h290

`define DCR_INIT_DIFIFO 6
`define DCR_INIT_DOFIFO 7
`define DCR_INIT_AOFIFO 8
`define DCR_IRQ_BITS 12
`define DCR_IRQ_DIHALF 4
`define DCR_IRQ_DIFULL 5
`define DCR_IRQ_PATDONE 7
`define DCR_IRQ_EXTTRIG 8
`define DCR_IRQ_CHAINTRIG 9
`define DCR_FSTAT_LSB 16
`define DCR_DMODE_FILT 4
`define DCR_DMODE_INCLK 8
`define DCR_DMODE_OUTCLK 11
`define DCR_DMODE_PATMODE 14
`define DCR_DMODE_MASK 32'h0000_7FFF
`define DCR_INCLK_ON 3'h4
`define DCR_OUTCLK_ON 3'h5
`define DCR_PAT_ENDLESS 5'h1F
`define DCR_PATTERN_MASK 32'h0000_FFFF
`define DCR_SCAN_MASK 32'h0001_FFFF
`define DCR_PACER_MASK 32'h03FF_FFFF
`define DCR_TRIG_MASK 32'h0000_00FF
`define DCR_RESET_VALUE 32'h0000_0000

`define DCR_SYS_CLK_HZ 10000000
`define DCR_BASE_1M_HZ 1000000
`define DCR_BASE_100K_HZ 100000
`define DCR_DIV_1M (`DCR_SYS_CLK_HZ / `DCR_BASE_1M_HZ)
`define DCR_DIV_100K (`DCR_SYS_CLK_HZ / `DCR_BASE_100K_HZ)

`endif

/* File: hdl/dcr_pkg.sv */
package dcr_pkg;
   typedef enum logic [1:0] {
      BASE_40M,
      BASE_10M,
      BASE_1M,
      BASE_100K
   } dcr_base_t;

   typedef enum {
      PAT_IDLE,
      PAT_RUN
   } dcr_pat_state_t;

   typedef logic [31:0] dcr_word_t;
endpackage

/* File: hdl/dcr_regbank.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dcr_cfg.svh"

module dcr_regbank #(
   parameter int FIFO_DEPTH = 16,
   parameter int FIFO_AW = 4
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [11:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [31:0] regWdata,
   output logic [31:0] regRdata,
   output logic regRdValid,
   input wire logic [3:0] cardIdSwitch,
   input wire logic [31:0] portIn,
   output logic [31:0] portOut,
   output logic [31:0] portOe,
   input wire logic diClkTick,
   input wire logic doClkTick,
   input wire logic [7:0] patternData,
   output logic patternReq,
   input wire logic aiPacerDone,
   input wire logic aiFifoHalf,
   input wire logic aiFifoFull,
   input wire logic diPacerDone,
   input wire logic aoPatternDone,
   input wire logic analogTrigEvt,
   input wire logic counterEvt,
   input wire logic extTrigIn,
   input wire logic chainTrigIn,
   output logic irqReq,
   output logic aoFifoReset,
   output logic aiPacerTick,
   output logic aiTrigger,
   output logic aiScanEnable,
   output logic [15:0] aiScanChannels,
   output logic [2:0] aiClkSource,
   output logic [2:0] aiTrigMode
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   function automatic logic hit(input logic [11:0] ofs);
      hit = regAddr == ofs;
   endfunction

   // Write 1 then 0 action: fires on a 0 write after a 1 write
   function automatic logic [11:0] seqClear(input logic [11:0] armed,
                                            input logic [11:0] wd);
      seqClear = armed & ~wd;
   endfunction

   logic wrInit, wrStat, wrMode, wrPort, wrPat, wrIen, wrScan, wrPacer;
   logic wrTrig, rdFifo;
   assign wrInit = regWrEn && hit(`DCR_OFS_INIT);
   assign wrStat = regWrEn && hit(`DCR_OFS_ISTAT);
   assign wrMode = regWrEn && hit(`DCR_OFS_DMODE);
   assign wrPort = regWrEn && hit(`DCR_OFS_PORT);
   assign wrPat = regWrEn && hit(`DCR_OFS_PATTERN);
   assign wrIen = regWrEn && hit(`DCR_OFS_IEN);
   assign wrScan = regWrEn && hit(`DCR_OFS_SCAN);
   assign wrPacer = regWrEn && hit(`DCR_OFS_PACER);
   assign wrTrig = regWrEn && hit(`DCR_OFS_TRIG);
   assign rdFifo = regRdEn && hit(`DCR_OFS_FDATA);

   // Pin synchronisers
   logic [3:0] cardSync1, cardSync2;
   logic [31:0] portSync1, portSync2;
   logic [1:0] trigSync1, trigSync2, trigPrev;
   always_ff @(posedge sys_clk) begin
      cardSync1 <= cardIdSwitch;
      cardSync2 <= cardSync1;
      portSync1 <= portIn;
      portSync2 <= portSync1;
      trigSync1 <= {chainTrigIn, extTrigIn};
      trigSync2 <= trigSync1;
      trigPrev <= trigSync2;
   end

   // Configuration registers
   logic [31:0] modeReg, patReg, scanReg, pacerReg, trigReg;
   logic [11:0] ienReg;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         modeReg <= `DCR_RESET_VALUE;
         patReg <= `DCR_RESET_VALUE;
         scanReg <= `DCR_RESET_VALUE;
         pacerReg <= `DCR_RESET_VALUE;
         trigReg <= `DCR_RESET_VALUE;
         ienReg <= '0;
      end else begin
         if (wrMode)
            modeReg <= regWdata & `DCR_DMODE_MASK;
         if (wrPat)
            patReg <= regWdata & `DCR_PATTERN_MASK;
         if (wrScan)
            scanReg <= regWdata & `DCR_SCAN_MASK;
         if (wrPacer)
            pacerReg <= regWdata & `DCR_PACER_MASK;
         if (wrTrig)
            trigReg <= regWdata & `DCR_TRIG_MASK;
         if (wrIen)
            ienReg <= regWdata[11:0];
      end
   end

   logic [3:0] portDir, filtEn;
   logic [2:0] inClkSel, outClkSel;
   logic patMode;
   assign portDir = modeReg[3:0];
   assign filtEn = modeReg[`DCR_DMODE_FILT +: 4];
   assign inClkSel = modeReg[`DCR_DMODE_INCLK +: 3];
   assign outClkSel = modeReg[`DCR_DMODE_OUTCLK +: 3];
   assign patMode = modeReg[`DCR_DMODE_PATMODE];

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         aiScanEnable <= 1'b0;
         aiScanChannels <= '0;
         aiClkSource <= '0;
         aiTrigMode <= '0;
      end else begin
         aiScanEnable <= scanReg[0];
         aiScanChannels <= scanReg[16:1];
         aiClkSource <= trigReg[2:0];
         aiTrigMode <= trigReg[7:5];
      end
   end

   // Initialize control: write 1 then 0 gives a one-cycle reset pulse
   logic [2:0] initArmed;
   logic diFifoClr, doFifoClr;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         initArmed <= '0;
         diFifoClr <= 1'b0;
         doFifoClr <= 1'b0;
         aoFifoReset <= 1'b0;
      end else begin
         diFifoClr <= wrInit && initArmed[0] &&
            !regWdata[`DCR_INIT_DIFIFO];
         doFifoClr <= wrInit && initArmed[1] &&
            !regWdata[`DCR_INIT_DOFIFO];
         aoFifoReset <= wrInit && initArmed[2] &&
            !regWdata[`DCR_INIT_AOFIFO];
         if (wrInit)
            initArmed <= regWdata[`DCR_INIT_DIFIFO +: 3];
      end
   end

   // Input filter: a lane with its filter bit set changes only after two equal byte samples in a row
   logic [31:0] portPrev, portFilt;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         portPrev <= '0;
         portFilt <= '0;
      end else begin
         portPrev <= portSync2;
         for (int p = 0; p < 4; p++) begin
            if (!filtEn[p] || portSync2[p*8 +: 8] == portPrev[p*8 +: 8])
               portFilt[p*8 +: 8] <= portSync2[p*8 +: 8];
         end
      end
   end

   // Static output latch; lanes of input ports ignore writes
   logic [31:0] outLatch;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         outLatch <= '0;
      end else if (wrPort) begin
         for (int p = 0; p < 4; p++) begin
            if (portDir[p])
               outLatch[p*8 +: 8] <= regWdata[p*8 +: 8];
         end
      end
   end

   // Port_a pattern engine
   dcr_pkg::dcr_pat_state_t patState;
   logic [10:0] patPoint;
   logic [4:0] patBurst;
   logic [7:0] patOut;
   logic patDone, patStep, patLastPoint;
   assign patStep = patState == dcr_pkg::PAT_RUN && doClkTick;
   assign patternReq = patStep;
   assign patLastPoint = patPoint == patReg[10:0];
   always_ff @(posedge sys_clk) begin
      if (srst || doFifoClr) begin
         patState <= dcr_pkg::PAT_IDLE;
         patPoint <= '0;
         patBurst <= '0;
         patOut <= '0;
         patDone <= 1'b0;
      end else begin
         patDone <= 1'b0;
         case (patState)
            dcr_pkg::PAT_IDLE: begin
               patPoint <= '0;
               patBurst <= '0;
               if (wrPat && patMode && portDir[0] &&
                   outClkSel == `DCR_OUTCLK_ON)
                  patState <= dcr_pkg::PAT_RUN;
            end
            dcr_pkg::PAT_RUN: begin
               if (!patMode) begin
                  patState <= dcr_pkg::PAT_IDLE;
               end else if (patStep) begin
                  patOut <= patternData;
                  patPoint <= patLastPoint ? 11'h000 : patPoint + 11'h001;
                  if (patLastPoint) begin
                     if (patReg[15:11] == `DCR_PAT_ENDLESS) begin
                        patBurst <= '0;
                     end else if (patBurst == patReg[15:11]) begin
                        patState <= dcr_pkg::PAT_IDLE;
                        patDone <= 1'b1;
                     end else begin
                        patBurst <= patBurst + 5'h01;
                     end
                  end
               end
            end
            default: patState <= dcr_pkg::PAT_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         portOut <= '0;
         portOe <= '0;
      end else begin
         portOut <= {outLatch[31:8],
            patMode ? patOut : outLatch[7:0]};
         for (int p = 0; p < 4; p++)
            portOe[p*8 +: 8] <= {8{portDir[p]}};
      end
   end

   // Input FIFO fed from port_c on the input clock
   logic [7:0] fifoMem [FIFO_DEPTH];
   logic [FIFO_AW-1:0] wrPtr, rdPtr;
   logic [FIFO_AW:0] fifoCount;
   logic fifoPush, fifoPop, fifoOvf;
   logic fifoEmpty, fifoFull, fifoHalf, fifoAlmFull, fifoAlmEmpty;
   assign fifoEmpty = fifoCount == '0;
   assign fifoFull = fifoCount == (FIFO_AW+1)'(FIFO_DEPTH);
   assign fifoHalf = fifoCount >= (FIFO_AW+1)'(FIFO_DEPTH / 2);
   assign fifoAlmFull = fifoCount >= (FIFO_AW+1)'(FIFO_DEPTH - 1);
   assign fifoAlmEmpty = fifoCount <= (FIFO_AW+1)'(1);
   assign fifoPush = diClkTick && inClkSel == `DCR_INCLK_ON &&
      !portDir[2] && !fifoFull;
   assign fifoPop = rdFifo && !fifoEmpty;
   always_ff @(posedge sys_clk) begin
      if (srst || diFifoClr) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fifoCount <= '0;
      end else begin
         if (fifoPush)
            wrPtr <= wrPtr + 1'b1;
         if (fifoPop)
            rdPtr <= rdPtr + 1'b1;
         if (fifoPush && !fifoPop)
            fifoCount <= fifoCount + 1'b1;
         else if (fifoPop && !fifoPush)
            fifoCount <= fifoCount - 1'b1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (fifoPush)
         fifoMem[wrPtr] <= portFilt[23:16];
   end
   // Overflow stays until the FIFO is reset through the init register
   // A sample lost in the clearing cycle still wins over the clear
   always_ff @(posedge sys_clk) begin
      if (srst)
         fifoOvf <= 1'b0;
      else if (diClkTick && inClkSel == `DCR_INCLK_ON && !portDir[2] &&
               fifoFull)
         fifoOvf <= 1'b1;
      else if (diFifoClr)
         fifoOvf <= 1'b0;
   end

   // Analog pacer: 40 MHz cannot be made from this clock and runs at 10 MHz
   logic [6:0] basePre;
   logic baseTick;
   logic [23:0] pacerCnt;
   always_comb begin
      case (dcr_pkg::dcr_base_t'(pacerReg[25:24]))
         dcr_pkg::BASE_1M: baseTick = basePre == 7'(`DCR_DIV_1M - 1);
         dcr_pkg::BASE_100K: baseTick = basePre == 7'(`DCR_DIV_100K - 1);
         default: baseTick = 1'b1;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (srst || wrPacer) begin
         basePre <= '0;
         pacerCnt <= '0;
         aiPacerTick <= 1'b0;
      end else begin
         basePre <= baseTick ? 7'h00 : basePre + 7'h01;
         aiPacerTick <= 1'b0;
         if (baseTick) begin
            if (pacerCnt == pacerReg[23:0]) begin
               pacerCnt <= '0;
               aiPacerTick <= 1'b1;
            end else begin
               pacerCnt <= pacerCnt + 24'h00_0001;
            end
         end
      end
   end

   logic [1:0] trigRise;
   assign trigRise = trigSync2 & ~trigPrev;
   always_ff @(posedge sys_clk) begin
      if (srst)
         aiTrigger <= 1'b0;
      else
         aiTrigger <= trigReg[4:3] == 2'b01 ? trigRise[1]
                                             : trigRise[0];
   end

   // Interrupt flags; a set in the clearing cycle wins
   logic [11:0] irqEvt, irqStat, irqArmed, irqClr;
   logic fifoHalfPrev, fifoFullPrev;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fifoHalfPrev <= 1'b0;
         fifoFullPrev <= 1'b0;
      end else begin
         fifoHalfPrev <= fifoHalf;
         fifoFullPrev <= fifoFull;
      end
   end
   assign irqEvt = {counterEvt, analogTrigEvt, trigRise[1], trigRise[0],
      patDone, aoPatternDone, fifoFull && !fifoFullPrev,
      fifoHalf && !fifoHalfPrev, diPacerDone, aiFifoFull, aiFifoHalf,
      aiPacerDone};
   assign irqClr = wrStat ? seqClear(irqArmed, regWdata[11:0]) : 12'h000;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irqStat <= '0;
         irqArmed <= '0;
      end else begin
         irqStat <= (irqStat & ~irqClr) | irqEvt;
         if (wrStat)
            irqArmed <= regWdata[11:0];
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst)
         irqReq <= 1'b0;
      else
         irqReq <= |(irqStat & ienReg);
   end

   // Read port, one cycle latency; unmapped offsets read zero
   logic [31:0] portLevel;
   always_comb begin
      for (int p = 0; p < 4; p++)
         portLevel[p*8 +: 8] = portDir[p] ? outLatch[p*8 +: 8]
                                          : portFilt[p*8 +: 8];
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         regRdata <= '0;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn) begin
            case (regAddr)
               `DCR_OFS_INIT:
                  regRdata <= {20'h0_0000, portDir, 4'h0, cardSync2};
               `DCR_OFS_ISTAT: regRdata <= {20'h0_0000, irqStat};
               `DCR_OFS_DMODE: regRdata <= modeReg;
               `DCR_OFS_PORT: regRdata <= portLevel;
               `DCR_OFS_FDATA:
                  regRdata <= {24'h00_0000, fifoMem[rdPtr]};
               `DCR_OFS_FSTAT:
                  regRdata <= {10'h000, fifoOvf, fifoAlmEmpty, fifoAlmFull,
                     fifoHalf, fifoFull, fifoEmpty, 16'h0000};
               `DCR_OFS_PATTERN: regRdata <= patReg;
               `DCR_OFS_IEN: regRdata <= {20'h0_0000, ienReg};
               `DCR_OFS_SCAN: regRdata <= scanReg;
               `DCR_OFS_PACER: regRdata <= pacerReg;
               `DCR_OFS_TRIG: regRdata <= trigReg;
               default: regRdata <= '0;
            endcase
         end
      end
   end

   // Checks
   irq_request_a: assert property (
      |(irqStat & ienReg) |=> irqReq)
      else $error("irq not raised for enabled flag");
   irq_quiet_a: assert property (
      !(|(irqStat & ienReg)) |=> !irqReq)
      else $error("irq raised without enabled flag");
   flag_clear_a: assert property (
      wrStat && irqArmed[0] && !regWdata[0] && !irqEvt[0] |=> !irqStat[0])
      else $error("flag not cleared by 1 then 0");
   flag_hold_a: assert property (
      irqStat[8] && !(wrStat && irqArmed[8] && !regWdata[8])
      |=> irqStat[8])
      else $error("flag lost without clear");
   ext_trig_a: assert property (
      $rose(trigSync2[0]) |=> irqStat[`DCR_IRQ_EXTTRIG])
      else $error("external trigger flag missing");
   fifo_pop_a: assert property (
      fifoPop && !fifoPush |=> fifoCount == $past(fifoCount) - 1'b1)
      else $error("read did not pop fifo");
   fifo_flags_a: assert property (
      fifoEmpty |-> !fifoFull && fifoAlmEmpty && !fifoHalf)
      else $error("fifo flags inconsistent");
   ao_reset_a: assert property (
      (wrInit && regWdata[`DCR_INIT_AOFIFO] ##1
       wrInit && !regWdata[`DCR_INIT_AOFIFO]) or
      (wrInit && regWdata[`DCR_INIT_AOFIFO] ##1 !wrInit ##1
       wrInit && !regWdata[`DCR_INIT_AOFIFO]) |=> aoFifoReset)
      else $error("ao fifo reset not pulsed");
   port_oe_a: assert property (
      wrMode ##1 1'b1 |=> portOe[31:24] == {8{portDir[3]}})
      else $error("port direction not applied");
   read_valid_a: assert property (
      regRdEn |=> regRdValid)
      else $error("read answer missing");
   read_once_a: assert property (
      !regRdEn |=> !regRdValid)
      else $error("read answer without request");
   pacer_tick_a: assert property (
      aiPacerTick && pacerReg[25:24] == 2'b01 && pacerReg[23:0] == 24'h1
      && !wrPacer ##1 !wrPacer |=> aiPacerTick)
      else $error("pacer period wrong");

   pat_done_c: cover property (patDone);
   fifo_full_c: cover property (fifoFull ##1 fifoPop);
   flag_clear_c: cover property (|irqClr);
   ovf_c: cover property ($rose(fifoOvf));
endmodule

`default_nettype wire

/* File: testbench/dcr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dcr_host_model (
   input wire logic sys_clk,
   output logic [11:0] regAddr,
   output logic regWrEn,
   output logic regRdEn,
   output logic [31:0] regWdata,
   input wire logic [31:0] regRdata,
   input wire logic regRdValid
);
   initial begin
      regAddr = 12'h000;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regWdata = 32'h0000_0000;
   end
   // Idle lines show the inverse, so a stale value never passes for a new one
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
   endtask
   // The answer stands exactly one cycle after the strobe; a missing
   // answer comes back unknown so that the caller's compare trips
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      @(posedge sys_clk);
      d = regRdValid === 1'b1 ? regRdata : 32'hxxxx_xxxx;
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dcr_cfg.svh"
module tb_top;
   logic sys_clk, srst, regWrEn, regRdEn, regRdValid, irqReq, aoFifoReset;
   logic diClkTick, extTrigIn, chainTrigIn, aiPacerTick, aiScanEnable;
   logic doClkTick, patternReq, aiTrigger;
   logic [11:0] regAddr;
   logic [31:0] regWdata, regRdata, portIn, portOut, portOe, rv;
   logic [3:0] cardIdSwitch;
   logic [6:0] evt;
   logic [15:0] aiScanChannels;
   logic [2:0] aiClkSource, aiTrigMode;
   int n_fail, n_compared, nAoRst, nTick, nReq, nTrig;
   time tPrev, tLast;
   dcr_regbank #(.FIFO_DEPTH(16), .FIFO_AW(4)) uut (.sys_clk(sys_clk),
      .srst(srst), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
      .cardIdSwitch(cardIdSwitch), .portIn(portIn), .portOut(portOut),
      .portOe(portOe), .diClkTick(diClkTick), .doClkTick(doClkTick),
      .patternData(8'h5A), .patternReq(patternReq), .aiPacerDone(evt[0]),
      .aiFifoHalf(evt[1]), .aiFifoFull(evt[2]), .diPacerDone(evt[3]),
      .aoPatternDone(evt[4]), .analogTrigEvt(evt[5]), .counterEvt(evt[6]),
      .extTrigIn(extTrigIn), .chainTrigIn(chainTrigIn), .irqReq(irqReq),
      .aoFifoReset(aoFifoReset), .aiPacerTick(aiPacerTick),
      .aiTrigger(aiTrigger), .aiScanEnable(aiScanEnable),
      .aiScanChannels(aiScanChannels), .aiClkSource(aiClkSource),
      .aiTrigMode(aiTrigMode));
   dcr_host_model host (.sys_clk(sys_clk), .regAddr(regAddr),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regWdata(regWdata),
      .regRdata(regRdata), .regRdValid(regRdValid));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (aoFifoReset === 1'b1) nAoRst++;
      if (patternReq === 1'b1) nReq++;
      if (aiTrigger === 1'b1) nTrig++;
      if (aiPacerTick === 1'b1) begin
         nTick++;
         tPrev = tLast;
         tLast = $time;
      end
   end
   task automatic chk(input logic [31:0] seen, exp, input string m);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t %s seen %h want %h", $time, m, seen, exp);
      end
   endtask
   task automatic stop_test;
      if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic t_ports;
      host.wr(`DCR_OFS_DMODE, 32'h0000_0005);
      host.wr(`DCR_OFS_PORT, 32'hAABB_CCDD);
      idle(5);
      host.rd(`DCR_OFS_INIT, rv);
      chk(rv, 32'h0000_050A, "hw status");
      chk(portOe, 32'h00FF_00FF, "oe");
      chk(portOut, 32'h00BB_00DD, "out lanes");
      host.rd(`DCR_OFS_PORT, rv);
      chk(rv, 32'h11BB_33DD, "port read");
   endtask
   task automatic t_rw;
      logic [11:0] a[5] = '{12'h210, 12'h220, 12'h22C, 12'h290, 12'h224};
      logic [31:0] m[5] = '{32'h0000_7FFF, 32'h0000_FFFF, 32'h0001_FFFF,
         32'h0000_00FF, 32'h0000_0FFF};
      for (int i = 0; i < 5; i++) begin
         host.wr(a[i], 32'hFFFF_FFFF);
         host.rd(a[i], rv);
         chk(rv, m[i], "rw mask");
      end
      host.rd(12'h208, rv);
      chk(rv, 32'h0000_0000, "unmapped");
      host.wr(`DCR_OFS_SCAN, 32'h0000_001D);
      host.wr(`DCR_OFS_TRIG, 32'h0000_00A5);
      idle(3);
      chk({31'h0, aiScanEnable}, 32'h0000_0001, "scan on");
      chk({16'h0, aiScanChannels}, 32'h0000_000E, "scan n");
      chk({29'h0, aiClkSource}, 32'h0000_0005, "clk src");
      chk({29'h0, aiTrigMode}, 32'h0000_0005, "trig mode");
   endtask
   task automatic t_irq;
      host.wr(`DCR_OFS_IEN, 32'h0000_0001);
      @(posedge sys_clk) evt <= 7'h40;
      @(posedge sys_clk) evt <= 7'h00;
      idle(3);
      host.rd(`DCR_OFS_ISTAT, rv);
      chk(rv, 32'h0000_0800, "masked flag");
      chk({31'h0, irqReq}, 32'h0000_0000, "irq masked");
      @(posedge sys_clk) evt <= 7'h7F;
      @(posedge sys_clk) evt <= 7'h00;
      extTrigIn <= 1'b1;
      chainTrigIn <= 1'b1;
      idle(8);
      host.rd(`DCR_OFS_ISTAT, rv);
      chk(rv, 32'h0000_0F4F, "all flags");
      chk({31'h0, irqReq}, 32'h0000_0001, "irq up");
      chk(nTrig, 32'h0000_0001, "ext trigger only");
      host.wr(`DCR_OFS_ISTAT, 32'h0000_0FFF);
      host.wr(`DCR_OFS_ISTAT, 32'h0000_0000);
      idle(2);
      host.rd(`DCR_OFS_ISTAT, rv);
      chk(rv, 32'h0000_0000, "cleared");
      chk({31'h0, irqReq}, 32'h0000_0000, "irq down");
      host.wr(`DCR_OFS_INIT, 32'h0000_0100);
      host.wr(`DCR_OFS_INIT, 32'h0000_0000);
      idle(3);
      chk(nAoRst, 32'h0000_0001, "ao reset");
   endtask
   task automatic t_fifo;
      logic [7:0] s[3] = '{8'h3C, 8'hC3, 8'h81};
      host.wr(`DCR_OFS_DMODE, 32'hFFFF_8401);
      host.rd(`DCR_OFS_FSTAT, rv);
      chk(rv, 32'h0011_0000, "fifo empty");
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk) portIn <= {8'h00, s[i], 16'h0000};
         idle(5);
         diClkTick <= 1'b1;
         @(posedge sys_clk) diClkTick <= 1'b0;
      end
      idle(2);
      host.rd(`DCR_OFS_FSTAT, rv);
      chk(rv, 32'h0000_0000, "fifo three");
      host.rd(`DCR_OFS_FDATA, rv);
      chk(rv, 32'h0000_003C, "fifo head");
      host.rd(`DCR_OFS_FDATA, rv);
      chk(rv, 32'h0000_00C3, "fifo pop");
      host.rd(`DCR_OFS_FSTAT, rv);
      chk(rv, 32'h0010_0000, "almost empty");
   endtask
   // Two points, two bursts: four requests, the fifth tick finds it idle
   task automatic t_pat;
      host.wr(`DCR_OFS_DMODE, 32'h0000_6801);
      host.wr(`DCR_OFS_PATTERN, 32'h0000_0801);
      repeat (5) begin
         @(posedge sys_clk) doClkTick <= 1'b1;
         @(posedge sys_clk) doClkTick <= 1'b0;
      end
      idle(2);
      chk(nReq, 32'h0000_0004, "pattern points");
      chk({24'h0, portOut[7:0]}, 32'h0000_005A, "pattern out");
      host.rd(`DCR_OFS_ISTAT, rv);
      chk(rv, 32'h0000_0080, "pattern done");
   endtask
   // Interval between ticks: base clock period times field plus one
   task automatic t_pace(input logic [31:0] w, input logic [31:0] ns);
      int n0, k;
      host.wr(`DCR_OFS_PACER, w);
      n0 = nTick;
      k = 0;
      while (nTick < n0 + 3 && k < 1000) begin
         @(posedge sys_clk);
         k++;
      end
      chk(32'(nTick >= n0 + 3), 32'h0000_0001, "pacer ticks");
      chk(32'(tLast - tPrev), ns, "pacer");
   endtask
   initial begin
      {srst, diClkTick, extTrigIn, chainTrigIn} = 4'b1000;
      doClkTick = 1'b0;
      nReq = 0;
      nTrig = 0;
      evt = 7'h00;
      cardIdSwitch = 4'hA;
      portIn = 32'h1122_3344;
      n_fail = 0;
      n_compared = 0;
      nAoRst = 0;
      nTick = 0;
      idle(20);
      srst <= 1'b0;
      t_ports();
      t_rw();
      t_irq();
      t_fifo();
      t_pat();
      t_pace(32'h0200_0000, 32'd1000);
      t_pace(32'h0100_0001, 32'd200);
      t_pace(32'h0300_0001, 32'd20000);
      stop_test();
   end
   // Whole run needs well under 3000 cycles
   initial begin
      #2000000;
      n_fail++;
      stop_test();
   end
endmodule
`default_nettype wire
